// ===== test_turn_signal_hazard_control.sv
module test_turn_signal_hazard_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Shortened timing, small enough for a quick run
  // ----------------------------------------------------------------
  localparam int QC = 40;
  localparam int HC = 8;
  localparam int FC = 4;
  localparam int SC = 6;
  localparam int LC = 20;
  localparam int GC = 6;
  logic clock = 1'b0;
  logic reset = 1'b1;
  tshc_pkg::tshc_pin_s pins = '0;
  tshc_pkg::tshc_pin_s pin_bus;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, lh_en, rh_en, relay_l, relay_r, tell_l, tell_r;
  tshc_pkg::tshc_drv_s drv;
  tshc_pkg::tshc_msg_s msg;
  logic [7:0] sense_l, sense_r;
  logic [1:0] cnt_l = 2'h2, cnt_r = 2'h2;
  logic leak_l = 1'b0;
  int err_total = 0;
  int compares = 0;
  tshc_pkg::tshc_msg_s mq[$];
  logic [31:0] d;
  logic e;

  initial begin
    forever #2 clock = ~clock;
  end
  always_comb begin
    pin_bus = pins;
    pin_bus.sense_l = sense_l;
    pin_bus.sense_r = sense_r;
  end
  // Cluster messages are one-cycle pulses, so collect them as they pass
  always @(posedge clock) begin
    if (msg.valid === 1'b1) begin
      mq.push_back(msg);
    end
  end

  tshc_turn_hazard #(.QUAL_CYC(QC), .HALF_CYC(HC), .FAST_CYC(FC),
    .SHORT_CYC(SC), .LONG_CYC(LC), .GAP_CYC(GC)) uut (
    .CLOCK(clock), .RESET(reset), .PINS(pin_bus), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LH_IND_EN(lh_en), .RH_IND_EN(rh_en), .RELAY_L(relay_l),
    .RELAY_R(relay_r), .TELL_L(tell_l), .TELL_R(tell_r), .DRV(drv),
    .MSG(msg));
  tshc_far_end far (.en_l(lh_en), .en_r(rh_en), .cnt_l(cnt_l),
    .cnt_r(cnt_r), .leak_l(leak_l), .sense_l(sense_l), .sense_r(sense_r));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic fail();
    err_total++;
    test_done();
  endtask : fail

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) fail();
  endtask : apb

  function automatic logic relay(input bit r);
    return r ? relay_r : relay_l;
  endfunction : relay

  // Width of the next whole on-pulse of one relay
  task automatic pulse_w(input bit r, output int w);
    int k, t;
    for (k = 0; k < 400 && relay(r) !== 1'b0; k++) @(posedge clock);
    for (t = 0; t < 400 && relay(r) !== 1'b1; t++) @(posedge clock);
    w = 0;
    while (relay(r) === 1'b1 && w < 400) begin
      @(posedge clock);
      w++;
    end
    if (k == 400 || t == 400 || w == 400) fail();
  endtask : pulse_w

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, tshc_pkg::CTRL_OFS, '0);
    chk(d[0], tshc_pkg::CTRL_BULB_EN_RST);
    apb(1'b0, tshc_pkg::COUNT_OFS, '0);
    chk(d[3:0], {tshc_pkg::LAMPS_OK, tshc_pkg::LAMPS_OK});
    apb(1'b0, tshc_pkg::STATUS_OFS, '0);
    chk(d[9:0], '0);
    apb(1'b0, 12'h00c, '0);
    chk(e, 1'b1);
    chk(d, '0);
  endtask : t_regs

  task automatic t_turn(input bit r, input logic [1:0] n,
    input tshc_pkg::tshc_code_e code);
    int w;
    mq.delete();
    if (r) cnt_r <= n;
    else cnt_l <= n;
    pins.ign <= 1'b1;
    pins.stalk_r <= r;
    pins.stalk_l <= !r;
    cyc(6);
    chk({lh_en, rh_en, drv.left, drv.right, drv.hazard},
      {!r, r, !r, r, 1'b0});
    pulse_w(r, w);
    chk(w, HC);
    chk(mq.size(), 0);
    cyc(QC + 4);
    chk(mq.size(), code != tshc_pkg::CODE_NONE);
    if (mq.size() > 0) chk({mq[0].side_r, mq[0].side_l, mq[0].code},
      {r, !r, code});
    pulse_w(r, w);
    if (n != 0 && (n != 1 || code != tshc_pkg::CODE_NONE)) begin
      chk(w, n == 1 ? FC : HC);
      chk(r ? drv.fast_r : drv.fast_l, n == 1);
    end
    repeat (12) begin
      @(posedge clock);
      chk({tell_l, tell_r}, {relay_l, relay_r});
    end
    apb(1'b0, tshc_pkg::COUNT_OFS, '0);
    chk(r ? d[3:2] : d[1:0], n);
    pins.stalk_r <= 1'b0;
    pins.stalk_l <= 1'b0;
    cyc(6);
    chk({lh_en, rh_en}, 2'b00);
    // Sense lags the release; no stuck report may follow it
    cyc(10);
    chk(mq.size(), code != tshc_pkg::CODE_NONE);
    mq.delete();
  endtask : t_turn

  task automatic haz_press();
    pins.haz_sw <= 1'b1;
    cyc(2);
    pins.haz_sw <= 1'b0;
    cyc(6);
  endtask : haz_press

  task automatic t_haz();
    mq.delete();
    cnt_l <= 2'h3;
    cnt_r <= 2'h1;
    pins.ign <= 1'b0;
    haz_press();
    chk({lh_en, rh_en, drv.hazard}, 3'b111);
    repeat (20) begin
      @(posedge clock);
      chk(relay_l, relay_r);
      chk({tell_l, tell_r}, {relay_l, relay_l});
    end
    cyc(QC);
    chk(mq.size(), 2);
    chk({mq[0].side_l, mq[0].code, mq[1].side_r, mq[1].code},
      {1'b1, tshc_pkg::CODE_TRAILER, 1'b1, tshc_pkg::CODE_BULB});
    haz_press();
    chk({lh_en, rh_en, drv.hazard}, 3'b000);
    pins.inertia <= 1'b1;
    cyc(6);
    chk(drv.hazard, 1'b1);
    cyc(60);
    chk({drv.hazard, lh_en, rh_en}, 3'b111);
    pins.inertia <= 1'b0;
    cyc(6);
    chk(drv.hazard, 1'b0);
    cnt_l <= 2'h2;
    cnt_r <= 2'h2;
    cyc(10);
    mq.delete();
  endtask : t_haz

  task automatic t_stuck();
    leak_l <= 1'b1;
    cyc(8);
    chk(mq.size(), 1);
    if (mq.size() > 0) chk({mq[0].side_r, mq[0].side_l, mq[0].code},
      {2'b00, tshc_pkg::CODE_STUCK});
    leak_l <= 1'b0;
    cyc(6);
  endtask : t_stuck

  task automatic t_sec(input int which, input int n, input int w_exp);
    int w, h;
    pins.arm <= which == 0;
    pins.superlock <= which == 1;
    pins.disarm <= which == 2;
    cyc(2);
    pins.arm <= 1'b0;
    pins.superlock <= 1'b0;
    pins.disarm <= 1'b0;
    repeat (n) begin
      pulse_w(1'b0, w);
      chk(w, w_exp);
    end
    h = 0;
    repeat (3 * GC) begin
      @(posedge clock);
      h += (relay_l === 1'b1 || relay_r === 1'b1);
    end
    chk(h, 0);
  endtask : t_sec

  task automatic t_alarm();
    pins.alarm <= 1'b1;
    cyc(6);
    chk({relay_l, relay_r}, 2'b11);
    pins.alarm <= 1'b0;
    cyc(6);
    chk({relay_l, relay_r}, 2'b00);
  endtask : t_alarm

  initial begin
    cyc(12);
    reset <= 1'b0;
    t_regs();
    t_turn(1'b0, 2'h2, tshc_pkg::CODE_NONE);
    t_turn(1'b1, 2'h3, tshc_pkg::CODE_TRAILER);
    t_turn(1'b0, 2'h1, tshc_pkg::CODE_BULB);
    t_turn(1'b1, 2'h0, tshc_pkg::CODE_SHORT);
    apb(1'b1, tshc_pkg::CTRL_OFS, 32'h00000000);
    t_turn(1'b0, 2'h1, tshc_pkg::CODE_NONE);
    apb(1'b1, tshc_pkg::CTRL_OFS, 32'h00000001);
    t_haz();
    t_stuck();
    t_sec(0, 1, SC);
    t_sec(1, 3, SC);
    t_sec(2, 1, LC);
    t_alarm();
    test_done();
  end
endmodule : test_turn_signal_hazard_control

// ===== tshc_far_end.sv
module tshc_far_end (
  // Side requests from the controller
  input wire logic en_l,
  input wire logic en_r,
  // Fitted lamps and fault injection from the bench
  input wire logic [1:0] cnt_l,
  input wire logic [1:0] cnt_r,
  input wire logic leak_l,
  // Lamp current codes back to the controller
  output logic [7:0] sense_l,
  output logic [7:0] sense_r
);
  timeunit 1ns;
  timeprecision 1ps;

  // Mid-band codes, so a band edge never decides the count
  function automatic logic [7:0] lamp_code(input logic [1:0] n);
    return {n, 6'h20};
  endfunction : lamp_code

  // A welded contact keeps carrying current with no request
  assign sense_l = en_l ? lamp_code(cnt_l) :
                   (leak_l ? 8'h60 : 8'h00);
  assign sense_r = en_r ? lamp_code(cnt_r) : 8'h00;
endmodule : tshc_far_end

// ===== tshc_pkg.sv
package tshc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] COUNT_OFS = 12'h008;
  localparam int CTRL_BULB_EN_BIT = 0;
  localparam logic CTRL_BULB_EN_RST = 1'b1;
  localparam int COUNT_L_LSB = 0;
  localparam int COUNT_R_LSB = 2;

  // ----------------------------------------------------------------
  // Lamp current bands (sense code to working lamp count)
  // ----------------------------------------------------------------
  localparam logic [7:0] BAND1 = 8'h40;
  localparam logic [7:0] BAND2 = 8'h80;
  localparam logic [7:0] BAND3 = 8'hc0;
  localparam logic [7:0] FLOW_MIN = 8'h10;
  localparam logic [1:0] LAMPS_OK = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned QUAL_MS = 160;
  localparam int unsigned HALF_MS = 330;
  localparam int unsigned FAST_HALF_MS = 165;
  localparam int unsigned SHORT_MS = 250;
  localparam int unsigned LONG_MS = 2000;
  localparam int unsigned GAP_MS = 250;
  localparam int unsigned QUAL_CYC = QUAL_MS * CLK_KHZ;
  localparam int unsigned HALF_CYC = HALF_MS * CLK_KHZ;
  localparam int unsigned FAST_CYC = FAST_HALF_MS * CLK_KHZ;
  localparam int unsigned SHORT_CYC = SHORT_MS * CLK_KHZ;
  localparam int unsigned LONG_CYC = LONG_MS * CLK_KHZ;
  localparam int unsigned GAP_CYC = GAP_MS * CLK_KHZ;
  // Cycles the sense inputs trail the enables, synchroniser included
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CODE_NONE = 3'h0,
    CODE_TRAILER = 3'h1,
    CODE_BULB = 3'h2,
    CODE_SHORT = 3'h3,
    CODE_STUCK = 3'h4
  } tshc_code_e;

  typedef enum logic [1:0] {
    SEC_IDLE = 2'b00,
    SEC_ON = 2'b01,
    SEC_GAP = 2'b10
  } tshc_sec_e;

  typedef struct packed {
    logic ign;
    logic stalk_l;
    logic stalk_r;
    logic haz_sw;
    logic inertia;
    logic arm;
    logic superlock;
    logic disarm;
    logic alarm;
    logic [7:0] sense_l;
    logic [7:0] sense_r;
  } tshc_pin_s;

  typedef struct packed {
    logic hazard;
    logic right;
    logic left;
    logic fast_r;
    logic fast_l;
  } tshc_drv_s;

  typedef struct packed {
    logic valid;
    logic side_r;
    logic side_l;
    tshc_code_e code;
  } tshc_msg_s;

  typedef struct packed {
    logic stuck;
    logic short_r;
    logic short_l;
    logic bulb_r;
    logic bulb_l;
    logic trailer_r;
    logic trailer_l;
    logic hazard;
    logic right;
    logic left;
  } tshc_status_s;

endpackage : tshc_pkg

// ===== tshc_turn_hazard.sv
module tshc_turn_hazard #(
  parameter int unsigned QUAL_CYC = tshc_pkg::QUAL_CYC,
  parameter int unsigned HALF_CYC = tshc_pkg::HALF_CYC,
  parameter int unsigned FAST_CYC = tshc_pkg::FAST_CYC,
  parameter int unsigned SHORT_CYC = tshc_pkg::SHORT_CYC,
  parameter int unsigned LONG_CYC = tshc_pkg::LONG_CYC,
  parameter int unsigned GAP_CYC = tshc_pkg::GAP_CYC
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Switch, security and sense pins (asynchronous)
  input wire tshc_pkg::tshc_pin_s PINS,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Indicator enables, relay coil drive and tell-tale drive
  output logic LH_IND_EN,
  output logic RH_IND_EN,
  output logic RELAY_L,
  output logic RELAY_R,
  output logic TELL_L,
  output logic TELL_R,
  // Messages to the driver module and the cluster
  output tshc_pkg::tshc_drv_s DRV,
  output tshc_pkg::tshc_msg_s MSG
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tshc_pkg::tshc_pin_s sync1;
    tshc_pkg::tshc_pin_s sync2;
    tshc_pkg::tshc_pin_s prev;
    logic haz_latch;
    logic [31:0] cad_cnt;
    logic phase;
    logic [31:0] qual_l;
    logic [31:0] qual_r;
    logic done_l;
    logic done_r;
    logic [1:0] cnt_l;
    logic [1:0] cnt_r;
    logic stuck;
    logic [1:0] settle;
    logic pend_l;
    logic pend_r;
    logic pend_s;
    tshc_pkg::tshc_code_e code_l;
    tshc_pkg::tshc_code_e code_r;
    tshc_pkg::tshc_sec_e sec_st;
    logic [1:0] sec_left;
    logic sec_long;
    logic [31:0] sec_tmr;
    logic bulb_en;
    logic lh_en;
    logic rh_en;
    logic relay_l;
    logic relay_r;
    logic tell_l;
    logic tell_r;
    tshc_pkg::tshc_drv_s drv;
    tshc_pkg::tshc_msg_s msg;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tshc_state_s;
  tshc_state_s s;
  tshc_state_s next_s;
  localparam logic [31:0] QUAL_LIM = 32'(QUAL_CYC);
  localparam logic [31:0] HALF_LAST = 32'(HALF_CYC - 1);
  localparam logic [31:0] FAST_LAST = 32'(FAST_CYC - 1);
  localparam logic [31:0] SHORT_LAST = 32'(SHORT_CYC - 1);
  localparam logic [31:0] LONG_LAST = 32'(LONG_CYC - 1);
  localparam logic [31:0] GAP_LAST = 32'(GAP_CYC - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] tshc_band(input logic [7:0] sense);
    if (sense >= tshc_pkg::BAND3) begin
      return 2'h3;
    end else if (sense >= tshc_pkg::BAND2) begin
      return 2'h2;
    end else if (sense >= tshc_pkg::BAND1) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction : tshc_band

  function automatic tshc_pkg::tshc_code_e tshc_classify(
    input logic [1:0] cnt,
    input logic bulb_en
  );
    unique case (cnt)
      2'h3: return tshc_pkg::CODE_TRAILER;
      2'h2: return tshc_pkg::CODE_NONE;
      2'h1: return bulb_en ? tshc_pkg::CODE_BULB : tshc_pkg::CODE_NONE;
      2'h0: return tshc_pkg::CODE_SHORT;
    endcase
  endfunction : tshc_classify

  // ----------------------------------------------------------------
  // Decoded conditions
  // ----------------------------------------------------------------
  tshc_pkg::tshc_pin_s p;
  logic haz_press, arm_edge, sl_edge, dis_edge;
  logic hazard, turn_l, turn_r, req_l, req_r, sec_flash;
  logic fail_l, fail_r, fast, flowing, idle, quiet;
  logic eval_l, eval_r;
  tshc_pkg::tshc_status_s status;

  always_comb begin
    p = s.sync2;
    haz_press = p.haz_sw & ~s.prev.haz_sw;
    arm_edge = p.arm & ~s.prev.arm;
    sl_edge = p.superlock & ~s.prev.superlock;
    dis_edge = p.disarm & ~s.prev.disarm;
    hazard = s.haz_latch | p.inertia;
    turn_l = p.ign & p.stalk_l & ~p.stalk_r;
    turn_r = p.ign & p.stalk_r & ~p.stalk_l;
    req_l = turn_l | hazard;
    req_r = turn_r | hazard;
    sec_flash = (s.sec_st == tshc_pkg::SEC_ON);
    fail_l = s.bulb_en & (s.cnt_l == 2'h1);
    fail_r = s.bulb_en & (s.cnt_r == 2'h1);
    fast = (req_l & fail_l) | (req_r & fail_r);
    flowing = (p.sense_l >= tshc_pkg::FLOW_MIN) |
              (p.sense_r >= tshc_pkg::FLOW_MIN);
    // Sense trails relays and enables through the pin synchroniser
    quiet = ~req_l & ~req_r & ~p.alarm & ~sec_flash &
            ~s.relay_l & ~s.relay_r & ~s.lh_en & ~s.rh_en;
    idle = quiet & (s.settle == 2'h0);
    // Sample only during an on phase so the lamps draw current
    eval_l = req_l & (s.qual_l >= QUAL_LIM) & ~s.done_l & s.relay_l;
    eval_r = req_r & (s.qual_r >= QUAL_LIM) & ~s.done_r & s.relay_r;
    status.stuck = s.stuck;
    status.short_r = (s.cnt_r == 2'h0);
    status.short_l = (s.cnt_l == 2'h0);
    status.bulb_r = fail_r;
    status.bulb_l = fail_l;
    status.trailer_r = (s.cnt_r == 2'h3);
    status.trailer_l = (s.cnt_l == 2'h3);
    status.hazard = hazard;
    status.right = turn_r;
    status.left = turn_l;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.sync1 = PINS;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    if (haz_press) begin
      next_s.haz_latch = ~s.haz_latch;
    end
    // Flash cadence, shared by both sides, restarted with the lamps on after a cycle with no request
    if (req_l | req_r) begin
      if (s.cad_cnt >= (fast ? FAST_LAST : HALF_LAST)) begin
        next_s.cad_cnt = 32'h0;
        next_s.phase = ~s.phase;
      end else begin
        next_s.cad_cnt = s.cad_cnt + 32'h1;
      end
    end else begin
      next_s.cad_cnt = 32'h0;
      next_s.phase = 1'b1;
    end
    // Alarm and security flashes drive both sides together
    next_s.relay_l = p.alarm | sec_flash | (req_l & s.phase);
    next_s.relay_r = p.alarm | sec_flash | (req_r & s.phase);
    next_s.tell_l = p.alarm | sec_flash | (req_l & s.phase);
    next_s.tell_r = p.alarm | sec_flash | (req_r & s.phase);
    next_s.lh_en = req_l;
    next_s.rh_en = req_r;
    next_s.drv.left = turn_l;
    next_s.drv.right = turn_r;
    next_s.drv.hazard = hazard;
    next_s.drv.fast_l = req_l & fail_l;
    next_s.drv.fast_r = req_r & fail_r;
    // Qualification timers, held at the limit
    next_s.qual_l = ~req_l ? 32'h0 :
                    (s.qual_l >= QUAL_LIM) ? s.qual_l : s.qual_l + 32'h1;
    next_s.qual_r = ~req_r ? 32'h0 :
                    (s.qual_r >= QUAL_LIM) ? s.qual_r : s.qual_r + 32'h1;
    next_s.done_l = s.done_l & req_l;
    next_s.done_r = s.done_r & req_r;
    // Cluster message: one per cycle, left before right before stuck
    next_s.msg.valid = 1'b0;
    if (s.pend_l) begin
      next_s.msg = '{1'b1, 1'b0, 1'b1, s.code_l};
      next_s.pend_l = 1'b0;
    end else if (s.pend_r) begin
      next_s.msg = '{1'b1, 1'b1, 1'b0, s.code_r};
      next_s.pend_r = 1'b0;
    end else if (s.pend_s) begin
      next_s.msg = '{1'b1, 1'b0, 1'b0, tshc_pkg::CODE_STUCK};
      next_s.pend_s = 1'b0;
    end
    // Each side judged on its own sense input
    if (eval_l) begin
      next_s.done_l = 1'b1;
      next_s.cnt_l = tshc_band(p.sense_l);
      next_s.code_l = tshc_classify(tshc_band(p.sense_l), s.bulb_en);
      if (tshc_classify(tshc_band(p.sense_l), s.bulb_en) !=
          tshc_pkg::CODE_NONE) begin
        next_s.pend_l = 1'b1;
      end
    end
    if (eval_r) begin
      next_s.done_r = 1'b1;
      next_s.cnt_r = tshc_band(p.sense_r);
      next_s.code_r = tshc_classify(tshc_band(p.sense_r), s.bulb_en);
      if (tshc_classify(tshc_band(p.sense_r), s.bulb_en) !=
          tshc_pkg::CODE_NONE) begin
        next_s.pend_r = 1'b1;
      end
    end
    next_s.settle = ~quiet ? tshc_pkg::SETTLE_CYC :
                    (s.settle == 2'h0) ? 2'h0 : s.settle - 2'h1;
    next_s.stuck = idle & flowing;
    if (idle & flowing & ~s.stuck) begin
      next_s.pend_s = 1'b1;
    end
    // Security flash sequencer; a new request restarts it
    if (dis_edge | sl_edge | arm_edge) begin
      next_s.sec_st = tshc_pkg::SEC_ON;
      next_s.sec_tmr = 32'h0;
      next_s.sec_long = dis_edge;
      next_s.sec_left = (~dis_edge & sl_edge) ? 2'h2 : 2'h0;
    end else begin
      unique case (s.sec_st)
        tshc_pkg::SEC_IDLE: begin
          next_s.sec_tmr = 32'h0;
        end
        tshc_pkg::SEC_ON: begin
          if (s.sec_tmr >= (s.sec_long ? LONG_LAST : SHORT_LAST)) begin
            next_s.sec_st = tshc_pkg::SEC_GAP;
            next_s.sec_tmr = 32'h0;
          end else begin
            next_s.sec_tmr = s.sec_tmr + 32'h1;
          end
        end
        tshc_pkg::SEC_GAP: begin
          if (s.sec_tmr < GAP_LAST) begin
            next_s.sec_tmr = s.sec_tmr + 32'h1;
          end else if (s.sec_left != 2'h0) begin
            next_s.sec_st = tshc_pkg::SEC_ON;
            next_s.sec_left = s.sec_left - 2'h1;
            next_s.sec_tmr = 32'h0;
          end else begin
            next_s.sec_st = tshc_pkg::SEC_IDLE;
          end
        end
        default: begin
          next_s.sec_st = tshc_pkg::SEC_IDLE;
        end
      endcase
    end
    // APB: data and PREADY both registered at the end of the first access cycle
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (PSEL & PENABLE & ~s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0;
      unique case (PADDR)
        tshc_pkg::CTRL_OFS: begin
          next_s.prdata[tshc_pkg::CTRL_BULB_EN_BIT] = s.bulb_en;
        end
        tshc_pkg::STATUS_OFS: begin
          next_s.prdata[$bits(status)-1:0] = status;
        end
        tshc_pkg::COUNT_OFS: begin
          next_s.prdata[tshc_pkg::COUNT_L_LSB +: 2] = s.cnt_l;
          next_s.prdata[tshc_pkg::COUNT_R_LSB +: 2] = s.cnt_r;
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // Write lands on the edge that completes the transfer
    if (PSEL & PENABLE & s.pready & PWRITE &
        (PADDR == tshc_pkg::CTRL_OFS)) begin
      next_s.bulb_en = PWDATA[tshc_pkg::CTRL_BULB_EN_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      s <= '0;
      s.phase <= 1'b1;
      s.cnt_l <= tshc_pkg::LAMPS_OK;
      s.cnt_r <= tshc_pkg::LAMPS_OK;
      s.bulb_en <= tshc_pkg::CTRL_BULB_EN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign LH_IND_EN = s.lh_en;
  assign RH_IND_EN = s.rh_en;
  assign RELAY_L = s.relay_l;
  assign RELAY_R = s.relay_r;
  assign TELL_L = s.tell_l;
  assign TELL_R = s.tell_r;
  assign DRV = s.drv;
  assign MSG = s.msg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  sequence tshc_disarm_seen;
    s.sync2.disarm && !s.prev.disarm;
  endsequence
  sequence tshc_long_on;
    s.sec_st == tshc_pkg::SEC_ON && s.sec_long;
  endsequence
  sequence tshc_lock3_seen;
    s.sync2.superlock && !s.prev.superlock && !s.sync2.disarm;
  endsequence
  AST_TURN_FWD: assert property (turn_l |=> DRV.left && LH_IND_EN)
    else $error("left turn not forwarded");
  AST_RELAY_CAUSE: assert property (RELAY_L |->
    $past(req_l || s.sync2.alarm || sec_flash))
    else $error("left relay on without a cause");
  AST_QUAL_TIME: assert property ($rose(s.done_l) |->
    $past(s.qual_l) >= QUAL_LIM)
    else $error("sense judged before qualification");
  AST_BAND: assert property ($rose(s.done_r) |->
    s.cnt_r == tshc_band($past(s.sync2.sense_r)))
    else $error("lamp count not from current band");
  AST_REPORT: assert property ($rose(s.pend_r) |-> ##[1:3]
    (MSG.valid && MSG.side_r && MSG.code == s.code_r))
    else $error("right result not reported");
  AST_HAZ_BOTH: assert property (hazard |=>
    DRV.hazard && LH_IND_EN && RH_IND_EN)
    else $error("hazard not on both sides");
  AST_STUCK: assert property ($rose(s.stuck) |->
    $past(flowing && !req_l && !req_r))
    else $error("stuck flag without idle current");
  AST_NO_BULB: assert property (MSG.valid && MSG.code ==
    tshc_pkg::CODE_BULB |-> s.bulb_en || $past(s.bulb_en, 2))
    else $error("bulb report while disabled");
  AST_TELL: assert property (TELL_L == RELAY_L && TELL_R == RELAY_R)
    else $error("tell-tale out of step");
  AST_LOCK3: assert property (tshc_lock3_seen |=>
    s.sec_st == tshc_pkg::SEC_ON && s.sec_left == 2'h2)
    else $error("superlock did not start three flashes");
  AST_UNLOCK: assert property (tshc_disarm_seen |=> tshc_long_on)
    else $error("unlock did not start long flash");
  AST_ALARM: assert property (s.sync2.alarm |=> RELAY_L && RELAY_R)
    else $error("alarm not flashing lamps");
  AST_HAZ_SW: assert property (haz_press |=>
    s.haz_latch != $past(s.haz_latch))
    else $error("hazard press did not toggle");

endmodule : tshc_turn_hazard
